// ===== prcc_pkg.sv
// constants for the core clock ratio controller
package prcc_pkg;
   localparam int CFG_W = 4;
   // ratio expressed in half steps: ratio = half_ratio / 2
   localparam int HR_W = 5;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam logic [3:0] CODE_BYPASS = 4'h3;
   localparam logic [3:0] CODE_OFF = 4'hF;
   localparam logic [3:0] CODE_SLOW = 4'h1;
   localparam logic [3:0] VCO_DIV2 = 4'h2;
   localparam logic [3:0] VCO_DIV8 = 4'h8;
   localparam logic [3:0] VCO_NONE = 4'h0;
   localparam logic [HR_W-1:0] HR_BYPASS = 5'h02;
   localparam logic [HR_W-1:0] HR_OFF = 5'h00;
   typedef enum {PRCC_RUN, PRCC_BYPASS, PRCC_OFF} prcc_mode_t;
endpackage

// ===== prcc_top.sv
// core clock ratio decode, clock generation model and nap gating
`timescale 1ns/1ns
`default_nettype none
module prcc_top (
   // reference clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // configuration and power state
   input wire logic [3:0] CFG_CODE,
   input wire logic NAP_REQ,
   // decoded configuration
   output logic [4:0] RATIO_HALF,
   output logic [3:0] VCO_DIV,
   output logic PLL_BYPASS,
   output logic PLL_OFF,
   // clocks out and status
   output logic CORE_CLK_EN,
   output logic TIMER_CLK_EN,
   output logic TEST_CLK,
   output logic HALTED
);
   logic [3:0] cfg_r;
   logic cfg_take_r;
   logic hold;
   prcc_pkg::prcc_mode_t mode;
   logic [4:0] ratio_nxt;
   logic [3:0] vco_div_nxt;
   logic bypass_nxt;
   logic off_nxt;
   logic test_clk_nxt;
   logic core_en_nxt;
   logic timer_en_nxt;
   logic halted_nxt;

   // ratio of code in half steps
   function automatic logic [4:0] half_ratio(input logic [3:0] c);
      case (c)
         4'h0: half_ratio = 5'h02;
         4'h1: half_ratio = 5'h02;
         4'h2: half_ratio = 5'h0E;
         4'h3: half_ratio = prcc_pkg::HR_BYPASS;
         4'h4: half_ratio = 5'h04;
         4'h5: half_ratio = 5'h0D;
         4'h6: half_ratio = 5'h05;
         4'h7: half_ratio = 5'h09;
         4'h8: half_ratio = 5'h06;
         4'h9: half_ratio = 5'h0B;
         4'hA: half_ratio = 5'h08;
         4'hB: half_ratio = 5'h0A;
         4'hC: half_ratio = 5'h03;
         4'hD: half_ratio = 5'h0C;
         4'hE: half_ratio = 5'h07;
         default: half_ratio = prcc_pkg::HR_OFF;
      endcase
   endfunction

   // loop mode of a code
   function automatic prcc_pkg::prcc_mode_t mode_of(input logic [3:0] c);
      case (c)
         prcc_pkg::CODE_BYPASS: mode_of = prcc_pkg::PRCC_BYPASS;
         prcc_pkg::CODE_OFF: mode_of = prcc_pkg::PRCC_OFF;
         default: mode_of = prcc_pkg::PRCC_RUN;
      endcase
   endfunction

   // vco divider; none while the loop is bypassed or off
   function automatic logic [3:0] vco_div_of(input logic [3:0] c);
      case (mode_of(c))
         prcc_pkg::PRCC_BYPASS: begin
            vco_div_of = prcc_pkg::VCO_NONE;
         end
         prcc_pkg::PRCC_OFF: begin
            vco_div_of = prcc_pkg::VCO_NONE;
         end
         default: begin
            if (c == prcc_pkg::CODE_SLOW) begin
               vco_div_of = prcc_pkg::VCO_DIV8;
            end else begin
               vco_div_of = prcc_pkg::VCO_DIV2;
            end
         end
      endcase
   endfunction

   // loop delivers a clock
   function automatic logic loop_runs(input logic [3:0] c);
      case (mode_of(c))
         prcc_pkg::PRCC_OFF: loop_runs = 1'b0;
         default: loop_runs = 1'b1;
      endcase
   endfunction

   // outputs other than HALTED stay parked until the held code is in place
   assign hold = SRST || cfg_take_r;
   assign mode = mode_of(cfg_r);

   // capture strobe, one cycle after reset release
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cfg_take_r <= 1'b1;
      end else begin
         cfg_take_r <= 1'b0;
      end
   end

   // code held until the next reset
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cfg_r <= prcc_pkg::CFG_RESET;
      end else if (cfg_take_r) begin
         cfg_r <= CFG_CODE;
      end
   end

   // next decoded configuration
   always_comb begin
      ratio_nxt = prcc_pkg::HR_OFF;
      vco_div_nxt = prcc_pkg::VCO_NONE;
      bypass_nxt = 1'b0;
      off_nxt = 1'b1;
      if (!hold) begin
         ratio_nxt = half_ratio(cfg_r);
         vco_div_nxt = vco_div_of(cfg_r);
         case (mode)
            prcc_pkg::PRCC_BYPASS: begin
               bypass_nxt = 1'b1;
               off_nxt = 1'b0;
            end
            prcc_pkg::PRCC_OFF: begin
               bypass_nxt = 1'b0;
               off_nxt = 1'b1;
            end
            default: begin
               bypass_nxt = 1'b0;
               off_nxt = 1'b0;
            end
         endcase
      end
   end

   // next clock enables, test clock and halt indicator
   always_comb begin
      test_clk_nxt = 1'b0;
      core_en_nxt = 1'b0;
      timer_en_nxt = 1'b0;
      halted_nxt = NAP_REQ;
      if (!hold && loop_runs(cfg_r)) begin
         test_clk_nxt = !TEST_CLK;
         core_en_nxt = !NAP_REQ;
         timer_en_nxt = 1'b1;
      end
   end

   // core to bus ratio in half steps
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         RATIO_HALF <= prcc_pkg::HR_OFF;
      end else begin
         RATIO_HALF <= ratio_nxt;
      end
   end

   // vco divider
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         VCO_DIV <= prcc_pkg::VCO_NONE;
      end else begin
         VCO_DIV <= vco_div_nxt;
      end
   end

   // loop bypass flag
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         PLL_BYPASS <= 1'b0;
      end else begin
         PLL_BYPASS <= bypass_nxt;
      end
   end

   // loop off flag, also high while parked
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         PLL_OFF <= 1'b1;
      end else begin
         PLL_OFF <= off_nxt;
      end
   end

   // test clock, one toggle per reference edge while the loop runs
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         TEST_CLK <= 1'b0;
      end else begin
         TEST_CLK <= test_clk_nxt;
      end
   end

   // core clock enable, stopped in nap
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         CORE_CLK_EN <= 1'b0;
      end else begin
         CORE_CLK_EN <= core_en_nxt;
      end
   end

   // timer and interrupt clock enable, kept in nap
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         TIMER_CLK_EN <= 1'b0;
      end else begin
         TIMER_CLK_EN <= timer_en_nxt;
      end
   end

   // halt indicator
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         HALTED <= 1'b0;
      end else begin
         HALTED <= halted_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== prcc_board.sv
// board model driving the configuration pins
`timescale 1ns/1ns
`default_nettype none
module prcc_board (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // code to present and upset request
   input wire logic up,
   input wire logic [3:0] code,
   // configuration pins
   output var logic [3:0] cfg
);
   initial cfg = 4'h0;
   // pins held outside reset, upset only on command
   always @(posedge clk) begin
      if (srst) cfg <= code;
      else if (up) cfg <= ~cfg;
   end
endmodule
`default_nettype wire

// ===== prcc_top_sva.sv
// assertions for the clock ratio controller
`timescale 1ns/1ns
`default_nettype none
module prcc_top_sva (
   // clock, reset and requests
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic NAP_REQ,
   input wire logic [3:0] CFG_CODE,
   // decoded configuration
   input wire logic [4:0] RATIO_HALF,
   input wire logic [3:0] VCO_DIV,
   input wire logic PLL_BYPASS,
   input wire logic PLL_OFF,
   // clocks out and status
   input wire logic CORE_CLK_EN,
   input wire logic TIMER_CLK_EN,
   input wire logic TEST_CLK,
   input wire logic HALTED
);
   logic [1:0] n_r;
   logic [3:0] c_r;
   wire logic run = n_r[1];
   wire logic full = n_r == 2'h3;
   always_ff @(posedge REF_CLK) begin
      n_r <= SRST ? 2'h0 : n_r + {1'b0, !full};
      if (n_r == 2'h0) c_r <= CFG_CODE;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   a_off_code: assert property (run && c_r == 4'hF |-> PLL_OFF
      && !TIMER_CLK_EN && RATIO_HALF == 5'h00) else $error("off");
   a_bypass_code: assert property (run && c_r == 4'h3 |->
      PLL_BYPASS && VCO_DIV == 4'h0) else $error("bypass");
   a_slow_code: assert property (run && c_r == 4'h1 |->
      VCO_DIV == 4'h8 && RATIO_HALF == 5'h02) else $error("slow");
   a_divide_two: assert property (run && c_r != 4'h1 && c_r != 4'h3
      && c_r != 4'hF |-> VCO_DIV == 4'h2 && !PLL_BYPASS) else $error("div");
   a_cfg_held: assert property (full |->
      $stable({RATIO_HALF, VCO_DIV, PLL_OFF})) else $error("held");
   a_test_toggle: assert property (full && !PLL_OFF && !PLL_BYPASS
      && !HALTED && !$past(HALTED) |-> $changed(TEST_CLK)) else $error("tck");
   a_halt_follow: assert property (full |->
      HALTED == $past(NAP_REQ)) else $error("halt");
   a_nap_gate: assert property (full && !PLL_OFF |->
      TIMER_CLK_EN && CORE_CLK_EN != HALTED) else $error("gate");
   c_nap: cover property (HALTED && !CORE_CLK_EN);
   c_bypass: cover property (run && PLL_BYPASS);
   c_off: cover property (run && PLL_OFF);
endmodule
bind prcc_top prcc_top_sva i_sva (.*);
`default_nettype wire

// ===== prcc_top_bench.sv
// bench for the clock ratio controller
`timescale 1ns/1ns
`default_nettype none
module prcc_top_bench;
   // ratio times two, code F down to 0
   localparam logic [79:0] TB = 80'h01D8352166495A413842;
   logic REF_CLK = 1'b0, SRST = 1'b1, NAP_REQ = 1'b0, up = 1'b0, t;
   logic PLL_BYPASS, PLL_OFF, CORE_CLK_EN, TIMER_CLK_EN, TEST_CLK, HALTED;
   logic [3:0] code = 4'h0, CFG_CODE, VCO_DIV;
   logic [4:0] RATIO_HALF;
   logic [10:0] e;
   wire logic [10:0] dec = {RATIO_HALF, VCO_DIV, PLL_BYPASS, PLL_OFF};
   wire logic [10:0] en = {8'h00, HALTED, CORE_CLK_EN, TIMER_CLK_EN};
   int miscompares = 0, checks_done = 0, cyc = 0;
   initial forever #4 REF_CLK = ~REF_CLK;
   prcc_board i_board (.clk(REF_CLK), .srst(SRST), .up, .code,
      .cfg(CFG_CODE));
   prcc_top i_dut (.*);
   task chk(logic [10:0] s, x);
      checks_done++;
      if (s !== x) begin
         miscompares++;
         $display("CHECK FAILED %0t saw %h want %h", $time, s, x);
      end
   endtask
   task step(int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask
   task rst(logic [3:0] c);
      @(posedge REF_CLK) {SRST, code} <= {1'b1, c};
      repeat (16) @(posedge REF_CLK);
      SRST <= 1'b0;
      step(4);
   endtask
   task t_codes;
      for (int c = 0; c < 16; c++) begin
         rst(c[3:0]);
         e = {TB[c*5+:5], c == 1 ? 4'h8 : c == 3 || c == 15 ? 4'h0 : 4'h2,
            c == 3, c == 15};
         chk(dec, e);
         chk(en, {9'h000, c != 15, c != 15});
      end
      $display("codes done");
   endtask
   task t_nap;
      rst(4'hA);
      @(posedge REF_CLK) NAP_REQ <= 1'b1;
      step(2);
      chk(en, 11'h005);
      @(posedge REF_CLK) NAP_REQ <= 1'b0;
      step(2);
      chk(en, 11'h003);
      $display("nap done");
   endtask
   task t_hold;
      rst(4'hC);
      @(posedge REF_CLK) up <= 1'b1;
      step(3);
      t = TEST_CLK;
      step(1);
      chk({10'h000, TEST_CLK}, {10'h000, ~t});
      chk(dec, 11'h0C8);
      @(posedge REF_CLK) up <= 1'b0;
      $display("hold done");
   endtask
   task conclude;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         conclude;
      end
   end
   initial begin
      t_codes;
      t_nap;
      t_hold;
      conclude;
   end
endmodule
`default_nettype wire
